// *** rtl/acc_pkg.sv ***
package acc_pkg;
  // Power-on hold, about 600 us at 50 MHz
  localparam int POR_HOLD_NS = 600000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POR_HOLD_CYCLES = POR_HOLD_NS / CLK_PERIOD_NS;
  // Start latency in device clock periods, tenths (28.5 and 105)
  localparam int START_DELAY_NORMAL_TENTHS = 285;
  localparam int START_DELAY_TURBO_TENTHS = 1050;
  localparam int START_DELAY_NORMAL_CYCLES = (START_DELAY_NORMAL_TENTHS + 9) / 10;
  localparam int START_DELAY_TURBO_CYCLES = (START_DELAY_TURBO_TENTHS + 9) / 10;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] INTEG_NONE = 2'h0;
  localparam logic [1:0] INTEG_INVERT = 2'h1;
  localparam logic [1:0] INTEG_CRC = 2'h2;
  localparam logic [1:0] CFG_REG_EXEMPT = 2'h0;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int NUM_PINS = 3;
  localparam int PIN_TWO = 2;
  localparam int DEFAULT_CONV_CYCLES = 64;

  typedef enum logic [2:0] {
    ACC_ST_SLEEP = 3'b000,
    ACC_ST_WAIT = 3'b001,
    ACC_ST_CONV = 3'b010,
    ACC_ST_DONE = 3'b011
  } acc_state_t;

  typedef enum logic [2:0] {
    ACC_TX_IDLE = 3'b000,
    ACC_TX_COUNT = 3'b001,
    ACC_TX_DATA = 3'b010,
    ACC_TX_CHK_HI = 3'b011,
    ACC_TX_CHK_LO = 3'b100,
    ACC_TX_INV = 3'b101
  } acc_tx_t;
endpackage : acc_pkg

// *** rtl/acc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (do_wr && !do_rd) begin
        count <= count + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule : acc_fifo
`default_nettype wire

// *** rtl/acc_crc.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_crc
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic update,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] next_crc;

  // Byte fed MSB first
  always_comb begin
    next_crc = crc;
    for (int i = 7; i >= 0; i--) begin
      if (next_crc[15] ^ data[i]) begin
        next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        next_crc = {next_crc[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc <= CRC_INIT;
    end else if (clear) begin
      crc <= CRC_INIT;
    end else if (update) begin
      crc <= next_crc;
    end
  end
endmodule : acc_crc
`default_nettype wire

// *** rtl/acc_control.sv ***
// How it works
// - Counter byte precedes result when enabled
// - Counter zeroed, increments per conversion, wraps
// - Counter zeroed on enable re-set, reset
// - Mode 01 sends inverted data copy
// - Mode 10 appends 16-bit checksum
// - CCITT polynomial, all-ones start; host checks
// - Checksum covers readback, results, counter; inverted copy only the first data byte
// - Three pins, each with direction bit
// - Pin two selects value or ready strobe
// - Any reset restores defaults, enters sleep
// - Hold reset 600 us after power
// - Two reset commands; host waits afterwards
// - Mode bit picks single or continuous
// - Single shot: one conversion per start
// - Single shot: config write, except to register 0, restarts conversion
// - Continuous: buffer result, start next immediately
// - Continuous start after 28.5/105 clocks, rounded up to 29/105
// - Continuous: config write, except to register 0, restarts conversion
// - Sleep command lets conversion finish
// - Ready falls on result, rises when latched
`timescale 1ns/1ps
`default_nettype none
module acc_control
  import acc_pkg::*;
#(
  parameter int POR_CYCLES = POR_HOLD_CYCLES,
  parameter int CONV_CYCLES = DEFAULT_CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic reset_cmd,
  input wire logic start_cmd,
  input wire logic sleep_command,
  input wire logic read_data_cmd,
  input wire logic cfg_write,
  input wire logic [1:0] cfg_write_reg,
  input wire logic conversion_mode_bit,
  input wire logic turbo_bit,
  input wire logic counter_enable_bit,
  input wire logic [1:0] integrity_mode,
  input wire logic [NUM_PINS-1:0] pin_direction_bits,
  input wire logic [NUM_PINS-1:0] pin_value_bits,
  input wire logic pin_two_function_select,
  input wire logic readback_req,
  input wire logic [7:0] readback_data,
  input wire logic modulator_done,
  input wire logic [23:0] modulator_result,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pin_read_bits,
  output logic result_ready_n,
  output logic analog_on,
  output logic converting,
  output logic comm_ready,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);
  acc_state_t state;
  acc_state_t next_state;
  acc_tx_t tx_state;
  logic soft_rst;
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
  logic [10:0] wait_cnt;
  logic [15:0] conv_cnt;
  logic sleep_pending;
  logic [7:0] conv_count;
  logic cnt_en_q;
  logic [23:0] result_buf;
  logic result_new;
  logic [23:0] out_word;
  logic [1:0] byte_idx;
  logic [1:0] byte_last;
  logic [7:0] cur_byte;
  logic [7:0] msb_byte;
  logic conv_finish;
  logic restart;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic crc_clear;
  logic crc_update;
  logic [15:0] crc;
  logic [15:0] chk_hold;
  logic [15:0] next_crc_out;

  assign soft_rst = rst || !reset_pin_n || reset_cmd;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_cnt <= '0;
    end else if (por_cnt != POR_CYCLES[$bits(por_cnt)-1:0]) begin
      por_cnt <= por_cnt + 1'b1;
    end
  end
  assign comm_ready = (por_cnt == POR_CYCLES[$bits(por_cnt)-1:0]);

  assign restart = cfg_write && (cfg_write_reg != CFG_REG_EXEMPT) && (state == ACC_ST_CONV);
  assign conv_finish = (state == ACC_ST_CONV) && !restart &&
                       (modulator_done || conv_cnt == 16'(CONV_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      ACC_ST_SLEEP: begin
        if (start_cmd && comm_ready) begin
          next_state = conversion_mode_bit ? ACC_ST_WAIT : ACC_ST_CONV;
        end
      end
      ACC_ST_WAIT: begin
        if (wait_cnt == 11'd0) begin
          next_state = ACC_ST_CONV;
        end
      end
      ACC_ST_CONV: begin
        if (conv_finish) begin
          next_state = ACC_ST_DONE;
        end
      end
      ACC_ST_DONE: begin
        if (conversion_mode_bit && !sleep_pending && !sleep_command) begin
          next_state = ACC_ST_CONV;
        end else begin
          next_state = ACC_ST_SLEEP;
        end
      end
      default: next_state = ACC_ST_SLEEP;
    endcase
    if (start_cmd && state != ACC_ST_SLEEP && comm_ready) begin
      next_state = conversion_mode_bit ? ACC_ST_WAIT : ACC_ST_CONV;
    end
  end

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      state <= ACC_ST_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      wait_cnt <= '0;
    end else if (start_cmd) begin
      wait_cnt <= turbo_bit ? 11'(START_DELAY_TURBO_CYCLES - 1)
                            : 11'(START_DELAY_NORMAL_CYCLES - 1);
    end else if (state == ACC_ST_WAIT && wait_cnt != 11'd0) begin
      wait_cnt <= wait_cnt - 11'd1;
    end
  end

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      conv_cnt <= '0;
    end else if (state != ACC_ST_CONV || restart || next_state != ACC_ST_CONV) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + 16'd1;
    end
  end

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      sleep_pending <= 1'b0;
    end else if (start_cmd || state == ACC_ST_SLEEP) begin
      sleep_pending <= 1'b0;
    end else if (sleep_command) begin
      sleep_pending <= 1'b1;
    end
  end

  assign analog_on = (state != ACC_ST_SLEEP);
  assign converting = (state == ACC_ST_CONV);

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      cnt_en_q <= 1'b0;
      conv_count <= CNT_RESET;
    end else begin
      cnt_en_q <= counter_enable_bit;
      if (counter_enable_bit && !cnt_en_q) begin
        conv_count <= CNT_RESET;
      end else if (conv_finish) begin
        conv_count <= conv_count + 8'd1;
      end
    end
  end

  // ready strobe, set wins over latch
  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      result_buf <= '0;
      result_new <= 1'b0;
    end else if (conv_finish) begin
      result_buf <= modulator_result;
      result_new <= 1'b1;
    end else if (read_data_cmd && tx_state == ACC_TX_IDLE) begin
      result_new <= 1'b0;
    end
  end
  assign result_ready_n = !result_new;

  always_ff @(posedge sys_clk or posedge soft_rst) begin
    if (soft_rst) begin
      tx_state <= ACC_TX_IDLE;
      out_word <= '0;
      byte_idx <= '0;
      byte_last <= '0;
      msb_byte <= '0;
      chk_hold <= '0;
    end else begin
      case (tx_state)
        ACC_TX_IDLE: begin
          if (read_data_cmd) begin
            out_word <= result_buf;
            byte_idx <= 2'd2;
            byte_last <= 2'd0;
            msb_byte <= result_buf[23:16];
            tx_state <= counter_enable_bit ? ACC_TX_COUNT : ACC_TX_DATA;
          end else if (readback_req) begin
            out_word <= {16'h0000, readback_data};
            byte_idx <= 2'd0;
            byte_last <= 2'd0;
            msb_byte <= readback_data;
            tx_state <= ACC_TX_DATA;
          end
        end
        ACC_TX_COUNT: begin
          if (f_ready) begin
            tx_state <= ACC_TX_DATA;
          end
        end
        ACC_TX_DATA: begin
          if (f_ready) begin
            if (byte_idx == byte_last) begin
              chk_hold <= crc_update ? next_crc_out : crc;
              if (integrity_mode == INTEG_CRC) begin
                tx_state <= ACC_TX_CHK_HI;
              end else if (integrity_mode == INTEG_INVERT) begin
                tx_state <= ACC_TX_INV;
              end else begin
                tx_state <= ACC_TX_IDLE;
              end
            end else begin
              byte_idx <= byte_idx - 2'd1;
            end
          end
        end
        ACC_TX_INV: begin
          if (f_ready) begin
            tx_state <= ACC_TX_IDLE;
          end
        end
        ACC_TX_CHK_HI: begin
          if (f_ready) begin
            tx_state <= ACC_TX_CHK_LO;
          end
        end
        ACC_TX_CHK_LO: begin
          if (f_ready) begin
            tx_state <= ACC_TX_IDLE;
          end
        end
        default: tx_state <= ACC_TX_IDLE;
      endcase
    end
  end

  assign cur_byte = out_word[8*byte_idx +: 8];

  // inverted copy of the first data byte only
  always_comb begin
    f_valid = 1'b1;
    f_data = 8'h00;
    case (tx_state)
      ACC_TX_COUNT: f_data = conv_count;
      ACC_TX_DATA: f_data = cur_byte;
      ACC_TX_INV: f_data = ~msb_byte;
      ACC_TX_CHK_HI: f_data = chk_hold[15:8];
      ACC_TX_CHK_LO: f_data = chk_hold[7:0];
      default: f_valid = 1'b0;
    endcase
  end

  assign crc_clear = (tx_state == ACC_TX_IDLE);
  assign crc_update = f_valid && f_ready &&
                      (tx_state == ACC_TX_COUNT || tx_state == ACC_TX_DATA);

  always_comb begin
    next_crc_out = crc;
    for (int i = 7; i >= 0; i--) begin
      if (next_crc_out[15] ^ f_data[i]) begin
        next_crc_out = {next_crc_out[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        next_crc_out = {next_crc_out[14:0], 1'b0};
      end
    end
  end

  acc_crc u_crc (
    .sys_clk(sys_clk),
    .rst(soft_rst),
    .clear(crc_clear),
    .update(crc_update),
    .data(f_data),
    .crc(crc)
  );

  acc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(soft_rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      always_ff @(posedge sys_clk or posedge soft_rst) begin
        if (soft_rst) begin
          pin_out[g] <= 1'b0;
          pin_oe_n[g] <= 1'b1;
          pin_read_bits[g] <= 1'b0;
        end else begin
          pin_oe_n[g] <= !pin_direction_bits[g];
          if (g == PIN_TWO && pin_two_function_select) begin
            pin_out[g] <= result_ready_n;
          end else begin
            pin_out[g] <= pin_value_bits[g];
          end
          pin_read_bits[g] <= pin_direction_bits[g] ? pin_value_bits[g] : pin_in[g];
        end
      end
    end
  endgenerate
endmodule : acc_control
`default_nettype wire

// *** dv/acc_control_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_control_asserts
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic reset_cmd,
  input wire logic start_cmd,
  input wire logic conversion_mode_bit,
  input wire logic turbo_bit,
  input wire logic [NUM_PINS-1:0] pin_direction_bits,
  input wire logic [NUM_PINS-1:0] pin_value_bits,
  input wire logic pin_two_function_select,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] pin_read_bits,
  input wire logic result_ready_n,
  input wire logic analog_on,
  input wire logic converting,
  input wire logic comm_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic ok;
  // Registered pins still show defaults one edge after any reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ok <= 1'h0;
    end else begin
      ok <= reset_pin_n && !reset_cmd && comm_ready;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !reset_pin_n || reset_cmd);

  AST_POR_IDLE: assert property (
    !comm_ready |-> !converting && !tx_valid)
    else $error("activity before power-on hold ended");
  AST_PIN_DIR: assert property (
    ok |-> pin_oe_n == ~$past(pin_direction_bits))
    else $error("pin enable not from direction");
  AST_PIN_OUT: assert property (
    ok |-> ((pin_out ^ $past(pin_value_bits)) & $past(pin_direction_bits) & 3'h3) == 3'h0)
    else $error("output pin not driven by value");
  AST_PIN_IN: assert property (
    ok |-> ((pin_read_bits ^ $past(pin_in)) & ~$past(pin_direction_bits)) == 3'h0)
    else $error("input pin level not read back");
  AST_PIN2_STROBE: assert property (
    ok && pin_direction_bits[2] && pin_two_function_select && $stable(pin_two_function_select)
    && $stable(pin_direction_bits) && $stable(result_ready_n) |-> pin_out[2] == result_ready_n)
    else $error("pin two not carrying ready strobe");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready && !reset_cmd |=> tx_valid && $stable(tx_data))
    else $error("output byte dropped while stalled");
  AST_ANALOG: assert property (
    converting |-> analog_on)
    else $error("converting with analog off");
  AST_START_NORM: assert property (
    comm_ready && start_cmd && conversion_mode_bit && !turbo_bit && !converting && !reset_cmd
    |=> !converting [*8] ##[1:40] converting)
    else $error("continuous start delay wrong");
endmodule : acc_control_asserts

bind acc_control acc_control_asserts chk_u (
  .sys_clk(sys_clk),
  .rst(rst),
  .reset_pin_n(reset_pin_n),
  .reset_cmd(reset_cmd),
  .start_cmd(start_cmd),
  .conversion_mode_bit(conversion_mode_bit),
  .turbo_bit(turbo_bit),
  .pin_direction_bits(pin_direction_bits),
  .pin_value_bits(pin_value_bits),
  .pin_two_function_select(pin_two_function_select),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n),
  .pin_read_bits(pin_read_bits),
  .result_ready_n(result_ready_n),
  .analog_on(analog_on),
  .converting(converting),
  .comm_ready(comm_ready),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .tx_data(tx_data)
);
`default_nettype wire

// *** dv/acc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  // 14-bit two's complement code to counts
  function automatic int temp_counts(input logic [13:0] code);
    return int'($signed(code));
  endfunction : temp_counts
  // Slow host: ready dropped while stalled
  assign tx_ready = !stall;
  always @(posedge sys_clk) begin
    if (!rst && tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule : acc_host_model
`default_nettype wire

// *** dv/adc_conversion_and_output_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_and_output_control_tb;
  import acc_pkg::*;
  typedef struct {
    logic rb;
    logic cen;
    logic [1:0] im;
    logic [23:0] v;
    int len;
  } acc_row_t;
  acc_row_t rows[8] = '{
    '{1'h0, 1'h0, 2'h0, 24'h123456, 3},
    '{1'h0, 1'h0, 2'h1, 24'h80ff01, 4},
    '{1'h0, 1'h0, 2'h2, 24'h7fffff, 5},
    '{1'h1, 1'h0, 2'h1, 24'h0000a5, 2},
    '{1'h1, 1'h0, 2'h2, 24'h00003c, 3},
    '{1'h0, 1'h1, 2'h2, 24'hfedcba, 6},
    '{1'h0, 1'h1, 2'h0, 24'h000001, 4},
    '{1'h1, 1'h1, 2'h0, 24'h00005a, 1}};
  logic sys_clk, rst, reset_pin_n, reset_cmd, start_cmd, sleep_command;
  logic read_data_cmd, cfg_write, conversion_mode_bit, turbo_bit, stall;
  logic counter_enable_bit, pin_two_function_select, readback_req, modulator_done;
  logic result_ready_n, analog_on, converting, comm_ready, tx_valid, tx_ready;
  logic [1:0] cfg_write_reg, integrity_mode;
  logic [2:0] pin_direction_bits, pin_value_bits, pin_in, pin_out, pin_oe_n, pin_read_bits;
  logic [7:0] readback_data, tx_data, exp_cnt;
  logic [23:0] modulator_result;
  logic [7:0] exp_q[$];
  int num_errors, checks, n;

  acc_control #(.POR_CYCLES(20), .CONV_CYCLES(16)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .reset_cmd(reset_cmd),
    .start_cmd(start_cmd),
    .sleep_command(sleep_command),
    .read_data_cmd(read_data_cmd),
    .cfg_write(cfg_write),
    .cfg_write_reg(cfg_write_reg),
    .conversion_mode_bit(conversion_mode_bit),
    .turbo_bit(turbo_bit),
    .counter_enable_bit(counter_enable_bit),
    .integrity_mode(integrity_mode),
    .pin_direction_bits(pin_direction_bits),
    .pin_value_bits(pin_value_bits),
    .pin_two_function_select(pin_two_function_select),
    .readback_req(readback_req),
    .readback_data(readback_data),
    .modulator_done(modulator_done),
    .modulator_result(modulator_result),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_read_bits(pin_read_bits),
    .result_ready_n(result_ready_n),
    .analog_on(analog_on),
    .converting(converting),
    .comm_ready(comm_ready),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_data(tx_data)
  );
  acc_host_model host_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .stall(stall),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick

  task automatic guard();
    tick(1);
    n++;
    if (n > 300) begin
      num_errors++;
      end_of_test();
    end
  endtask : guard

  task automatic waitc(input logic lvl);
    n = 0;
    while (converting !== lvl) guard();
  endtask : waitc

  task automatic done();
    modulator_done <= 1'h1;
    tick(1);
    modulator_done <= 1'h0;
    exp_cnt++;
  endtask : done

  task automatic conv();
    start_cmd <= 1'h1;
    tick(1);
    start_cmd <= 1'h0;
    waitc(1'h1);
    done();
    waitc(1'h0);
    tick(2);
  endtask : conv

  function automatic logic [15:0] crc16(input int s);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = s; i < exp_q.size(); i++) begin
      for (int j = 7; j >= 0; j--) begin
        c = {c[14:0], 1'h0} ^ ((c[15] ^ exp_q[i][j]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction : crc16

  task automatic request(input acc_row_t r);
    int s;
    logic [15:0] c;
    s = exp_q.size();
    if (!r.rb && r.cen) exp_q.push_back(exp_cnt);
    if (!r.rb) exp_q.push_back(r.v[23:16]);
    if (!r.rb) exp_q.push_back(r.v[15:8]);
    exp_q.push_back(r.v[7:0]);
    c = crc16(s);
    if (r.im == 2'h1) exp_q.push_back(~exp_q[s]);
    if (r.im == 2'h2) exp_q.push_back(c[15:8]);
    if (r.im == 2'h2) exp_q.push_back(c[7:0]);
    check(exp_q.size() - s, r.len);
    readback_data <= r.v[7:0];
    readback_req <= r.rb;
    read_data_cmd <= !r.rb;
    tick(1);
    readback_req <= 1'h0;
    read_data_cmd <= 1'h0;
  endtask : request

  task automatic collect();
    n = 0;
    while (host_u.got.size() < exp_q.size()) guard();
    tick(8);
    check(host_u.got.size(), exp_q.size());
    foreach (exp_q[i]) check(host_u.got[i], exp_q[i]);
    check(tx_valid, 1'h0);
    host_u.got.delete();
    exp_q.delete();
  endtask : collect

  task automatic cstart(input int lo, input int hi);
    start_cmd <= 1'h1;
    tick(1);
    start_cmd <= 1'h0;
    waitc(1'h1);
    check(n >= lo && n <= hi, 1'h1);
  endtask : cstart

  task automatic sleep_stop();
    sleep_command <= 1'h1;
    tick(1);
    sleep_command <= 1'h0;
    tick(2);
    check(converting, 1'h1);
    done();
    waitc(1'h0);
    tick(5);
    check({converting, analog_on}, 2'h0);
  endtask : sleep_stop

  initial begin
    rst = 1'h1;
    reset_pin_n = 1'h1;
    {reset_cmd, start_cmd, sleep_command, read_data_cmd, cfg_write, stall} = '0;
    {conversion_mode_bit, turbo_bit, counter_enable_bit, pin_two_function_select} = '0;
    {readback_req, modulator_done, cfg_write_reg, integrity_mode} = '0;
    {pin_direction_bits, pin_value_bits, pin_in} = '0;
    readback_data = 8'h00;
    modulator_result = 24'h000000;
    exp_cnt = 8'h00;
    num_errors = 0;
    checks = 0;
    tick(10);
    rst <= 1'h0;
    tick(1);
    check({result_ready_n, tx_valid, converting, pin_oe_n}, 6'h27);
    tick(16);
    check(comm_ready, 1'h0);
    tick(6);
    check(comm_ready, 1'h1);
    foreach (rows[i]) begin
      if (rows[i].cen && !counter_enable_bit) exp_cnt = 8'h00;
      counter_enable_bit <= rows[i].cen;
      integrity_mode <= rows[i].im;
      modulator_result <= rows[i].v;
      tick(1);
      if (!rows[i].rb) conv();
      if (!rows[i].rb) check(result_ready_n, 1'h0);
      request(rows[i]);
      collect();
      check(result_ready_n, 1'h1);
    end
    pin_direction_bits <= 3'h3;
    pin_value_bits <= 3'h5;
    pin_in <= 3'h6;
    tick(3);
    check({pin_oe_n, pin_out[1:0], pin_read_bits[2]}, 6'h23);
    pin_direction_bits <= 3'h7;
    pin_value_bits <= 3'h1;
    pin_two_function_select <= 1'h1;
    tick(3);
    check(pin_out[2], 1'h1);
    counter_enable_bit <= 1'h0;
    integrity_mode <= 2'h2;
    modulator_result <= 24'hc0ffee;
    tick(2);
    counter_enable_bit <= 1'h1;
    exp_cnt = 8'h00;
    tick(2);
    repeat (256) conv();
    check(pin_out[2], 1'h0);
    request('{1'h0, 1'h1, 2'h2, 24'hc0ffee, 6});
    collect();
    start_cmd <= 1'h1;
    tick(1);
    start_cmd <= 1'h0;
    waitc(1'h1);
    cfg_write <= 1'h1;
    cfg_write_reg <= 2'h1;
    tick(1);
    cfg_write <= 1'h0;
    tick(15);
    check(converting, 1'h1);
    done();
    waitc(1'h0);
    tick(10);
    check({converting, analog_on}, 2'h0);
    request('{1'h0, 1'h1, 2'h2, 24'hc0ffee, 6});
    collect();
    // Host stalls until the buffer refuses
    stall <= 1'h1;
    conv();
    request('{1'h0, 1'h1, 2'h2, 24'hc0ffee, 6});
    tick(8);
    request('{1'h1, 1'h0, 2'h2, 24'h000077, 3});
    tick(10);
    check(tx_valid, 1'h1);
    stall <= 1'h0;
    collect();
    conversion_mode_bit <= 1'h1;
    cstart(26, 32);
    sleep_stop();
    turbo_bit <= 1'h1;
    cstart(100, 110);
    done();
    tick(2);
    check(converting, 1'h1);
    cfg_write <= 1'h1;
    cfg_write_reg <= 2'h2;
    tick(1);
    cfg_write <= 1'h0;
    tick(15);
    check(converting, 1'h1);
    done();
    tick(2);
    sleep_stop();
    reset_cmd <= 1'h1;
    tick(1);
    reset_cmd <= 1'h0;
    tick(2);
    check({result_ready_n, tx_valid, converting}, 3'h4);
    tick(5);
    cstart(100, 110);
    reset_pin_n <= 1'h0;
    tick(3);
    reset_pin_n <= 1'h1;
    tick(2);
    check({result_ready_n, tx_valid, converting}, 3'h4);
    check(host_u.temp_counts(14'h3ce0), 32'hfffffce0);
    check(host_u.temp_counts(14'h0960), 32'h00000960);
    end_of_test();
  end
endmodule : adc_conversion_and_output_control_tb
`default_nettype wire
